// [pkg/lpc_pkg.sv]
// shared constants and types of the low-power and clock-switch controller
`default_nettype none
package lpc_pkg;
    // power_mode_control_reg layout
    localparam int unsigned PM_FAST_OSC_BIT = 7;
    localparam int unsigned PM_SLOW_OSC_BIT = 6;
    localparam int unsigned PM_MAIN_SEL_BIT = 5;
    localparam int unsigned PM_HALT_BIT     = 2;
    localparam logic [7:0]  PM_RESET        = 8'h80;
    localparam logic [7:0]  PM_WRITE_MASK   = 8'hE4;

    // time_base_control_reg layout
    localparam int unsigned TB_ENABLE_BIT   = 7;
    localparam int unsigned TB_SEL_MSB      = 2;
    localparam int unsigned TB_SEL_W        = 3;
    localparam logic [7:0]  TB_RESET        = 8'h00;
    localparam logic [7:0]  TB_WRITE_MASK   = 8'h87;
    localparam int unsigned TB_SRC_N        = 8;

    localparam int unsigned PERIPH_N        = 8;
    localparam logic [15:0] PC_ADVANCE      = 16'h0002;

    // timing
    localparam int unsigned CLK_PERIOD_NS   = 4;
    localparam int unsigned CLK_SYNC_NS     = 40;
    localparam int unsigned MUX_DEAD_NS     = 8;
    localparam int unsigned SYNC_CYCLES_I   =
        (CLK_SYNC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DEAD_CYCLES_I   =
        (MUX_DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W           = 4;
    localparam logic [CNT_W-1:0] SYNC_CYCLES =
        CNT_W'(SYNC_CYCLES_I < 1 ? 1 : SYNC_CYCLES_I);
    localparam logic [CNT_W-1:0] DEAD_CYCLES =
        CNT_W'(DEAD_CYCLES_I < 1 ? 1 : DEAD_CYCLES_I);
    localparam logic [CNT_W-1:0] CNT_ZERO    = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE     = 4'h1;

    typedef enum logic [1:0] {
        MODE_SINGLE_RUN,
        MODE_DUAL_FAST,
        MODE_SLOW_FAST_ON,
        MODE_SLOW_FAST_OFF
    } lpc_mode_e;

    typedef enum logic [1:0] {
        HS_RUN,
        HS_PENDING,
        HS_HALTED
    } lpc_halt_e;
endpackage
`default_nettype wire

// [rtl/lpc_fall_detect.sv]
// falling-edge detector for the selected time base source level
`timescale 1ns/100ps
`default_nettype none
module lpc_fall_detect (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic level,
    output logic      fall
);
    logic levelPrev_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            levelPrev_q <= 1'b0;
        end else begin
            levelPrev_q <= level;
        end
    end

    assign fall = levelPrev_q & ~level;
endmodule
`default_nettype wire

// [rtl/lpc_clk_switch.sv]
// break-before-make sequencer for the main clock source enables
`timescale 1ns/100ps
`default_nettype none
module lpc_clk_switch (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic targetSlow,
    output logic      fastEn_q,
    output logic      slowEn_q,
    output logic      onSlow_q
);
    logic [lpc_pkg::CNT_W-1:0] dead_q;

    // both gates are closed for the dead time so no shortened pulse reaches the mux
    always_ff @(posedge clk) begin
        if (rst) begin
            fastEn_q <= 1'b1;
            slowEn_q <= 1'b0;
            onSlow_q <= 1'b0;
            dead_q   <= lpc_pkg::CNT_ZERO;
        end else if (targetSlow != onSlow_q) begin
            if (fastEn_q | slowEn_q) begin
                fastEn_q <= 1'b0;
                slowEn_q <= 1'b0;
                dead_q   <= lpc_pkg::DEAD_CYCLES;
            end else if (dead_q > lpc_pkg::CNT_ONE) begin
                dead_q <= dead_q - lpc_pkg::CNT_ONE;
            end else begin
                onSlow_q <= targetSlow;
                fastEn_q <= ~targetSlow;
                slowEn_q <= targetSlow;
                dead_q   <= lpc_pkg::CNT_ZERO;
            end
        end
    end
endmodule
`default_nettype wire

// [rtl/lpc_power_ctrl.sv]
// low-power halt and system clock switching controller
// Functional notes
// - Deep idle/sleep: only the time base timer keeps its clock.
// - Deep idle/sleep: memory, CPU registers, status word, port latches frozen.
// - Deep idle/sleep: held program counter is initiating instruction address plus two.
// - Writing halt bit to one enters deep idle/sleep.
// - Release clears halt bit and returns to the previous operating mode.
// - Time base enabled at entry sets the time base interrupt latch.
// - Reset releases deep idle/sleep; afterwards single-clock run mode.
// - Entry and release happen whatever the time base enable bit holds.
// - Enables AND zero: exit on selected source falling edge, no interrupt.
// - Enables all one: exit on falling edge, then service time base interrupt.
// - Exit timing is asynchronous; halt may be shorter than selected period.
// - Watchdog interrupt just before entry: serve it, do not enter.
// - To slow: set main select bit 5, then clear fast oscillator bit 7.
// - To fast: enable fast oscillator, wait warm-up, then clear select bit.
// - After select bit clears, keep slow clock until synchronisation completes.
// - Reset also ends slow mode; restart in single-clock run mode.
// - Clearing fast oscillator bit while select is zero raises clock reset.
`timescale 1ns/100ps
`default_nettype none
module lpc_power_ctrl (
    input  wire logic                            clk,
    input  wire logic                            rst,
    input  wire logic                            ctrlWrEn,
    input  wire logic [7:0]                      ctrlWrData,
    input  wire logic                            tbCtrlWrEn,
    input  wire logic [7:0]                      tbCtrlWrData,
    input  wire logic                            masterIrqEnable,
    input  wire logic                            tbIrqEnable,
    input  wire logic                            tbIrqLatchClr,
    input  wire logic [lpc_pkg::TB_SRC_N-1:0]    tbSrcLevels,
    input  wire logic                            instrDone,
    input  wire logic [15:0]                     instrAddr,
    input  wire logic                            wdtIrq,
    output logic      [7:0]                      ctrlRdData_q,
    output logic      [7:0]                      tbCtrlRdData_q,
    output logic      [lpc_pkg::PERIPH_N-1:0]    periphClkEn_q,
    output logic                                 tbtClkEn_q,
    output logic                                 cpuHold_q,
    output logic      [15:0]                     heldPc_q,
    output logic                                 tbIrqLatch_q,
    output logic                                 tbIrqService_q,
    output logic                                 lowPowerActive_q,
    output logic                                 fastClkEn_q,
    output logic                                 slowClkEn_q,
    output logic                                 fastOscEn_q,
    output logic                                 slowOscEn_q,
    output logic      [1:0]                      opMode_q,
    output logic                                 sysClkRstReq_q
);
    logic [7:0]                  pmReg_q;
    logic [7:0]                  tbReg_q;
    lpc_pkg::lpc_halt_e          halt_q;
    lpc_pkg::lpc_mode_e          mode_q;
    logic                        targetSlow_q;
    logic [lpc_pkg::CNT_W-1:0]   sync_q;
    logic                        selLevel;
    logic                        tbFall;
    logic                        muxFastEn;
    logic                        muxSlowEn;
    logic                        muxOnSlow;
    logic                        wrAllowed;
    logic                        xenClearBad;
    logic                        enterNow;
    logic                        abortNow;
    logic                        releaseNow;
    logic                        irqPath;
    logic [2:0]                  tbSel;

    assign tbSel     = tbReg_q[lpc_pkg::TB_SEL_MSB:0];
    assign selLevel  = tbSrcLevels[tbSel];
    assign wrAllowed = ctrlWrEn && (halt_q != lpc_pkg::HS_HALTED);

    // fast oscillator is still the running clock when select stays at zero
    assign xenClearBad = wrAllowed
        && pmReg_q[lpc_pkg::PM_FAST_OSC_BIT]
        && !ctrlWrData[lpc_pkg::PM_FAST_OSC_BIT]
        && !pmReg_q[lpc_pkg::PM_MAIN_SEL_BIT]
        && !ctrlWrData[lpc_pkg::PM_MAIN_SEL_BIT];

    // a watchdog request at the boundary wins over the halt request
    assign abortNow   = (halt_q == lpc_pkg::HS_PENDING) && instrDone && wdtIrq;
    assign enterNow   = (halt_q == lpc_pkg::HS_PENDING) && instrDone && !wdtIrq;
    // the time base enable bit gates neither entry nor release
    assign releaseNow = (halt_q == lpc_pkg::HS_HALTED) && tbFall;
    assign irqPath    = masterIrqEnable && tbIrqEnable
        && tbReg_q[lpc_pkg::TB_ENABLE_BIT];

    lpc_fall_detect u_fall (
        .clk   (clk),
        .rst   (rst),
        .level (selLevel),
        .fall  (tbFall)
    );

    lpc_clk_switch u_switch (
        .clk        (clk),
        .rst        (rst),
        .targetSlow (targetSlow_q),
        .fastEn_q   (muxFastEn),
        .slowEn_q   (muxSlowEn),
        .onSlow_q   (muxOnSlow)
    );

    // halt sequencing
    always_ff @(posedge clk) begin
        if (rst) begin
            halt_q <= lpc_pkg::HS_RUN;
        end else begin
            unique case (halt_q)
                lpc_pkg::HS_RUN: begin
                    if (wrAllowed && ctrlWrData[lpc_pkg::PM_HALT_BIT]) begin
                        halt_q <= lpc_pkg::HS_PENDING;
                    end
                end
                lpc_pkg::HS_PENDING: begin
                    if (abortNow) begin
                        halt_q <= lpc_pkg::HS_RUN;
                    end else if (enterNow) begin
                        halt_q <= lpc_pkg::HS_HALTED;
                    end
                end
                lpc_pkg::HS_HALTED: begin
                    if (releaseNow) begin
                        halt_q <= lpc_pkg::HS_RUN;
                    end
                end
                default: begin
                    halt_q <= lpc_pkg::HS_RUN;
                end
            endcase
        end
    end

    // power mode control register
    always_ff @(posedge clk) begin
        if (rst) begin
            pmReg_q <= lpc_pkg::PM_RESET;
        end else begin
            if (wrAllowed) begin
                pmReg_q <= ctrlWrData & lpc_pkg::PM_WRITE_MASK;
                if (halt_q != lpc_pkg::HS_RUN) begin
                    pmReg_q[lpc_pkg::PM_HALT_BIT] <= pmReg_q[lpc_pkg::PM_HALT_BIT];
                end
                if (xenClearBad) begin
                    pmReg_q[lpc_pkg::PM_FAST_OSC_BIT] <= 1'b1;
                end
            end
            if (abortNow || releaseNow) begin
                pmReg_q[lpc_pkg::PM_HALT_BIT] <= 1'b0;
            end
        end
    end

    // time base control register; frozen while halted
    always_ff @(posedge clk) begin
        if (rst) begin
            tbReg_q <= lpc_pkg::TB_RESET;
        end else if (tbCtrlWrEn && (halt_q != lpc_pkg::HS_HALTED)) begin
            tbReg_q <= tbCtrlWrData & lpc_pkg::TB_WRITE_MASK;
        end
    end

    // main clock target; a return to fast waits out the synchronisation time
    always_ff @(posedge clk) begin
        if (rst) begin
            targetSlow_q <= 1'b0;
            sync_q       <= lpc_pkg::CNT_ZERO;
        end else if (pmReg_q[lpc_pkg::PM_MAIN_SEL_BIT]) begin
            targetSlow_q <= 1'b1;
            sync_q       <= lpc_pkg::CNT_ZERO;
        end else if (targetSlow_q) begin
            if (sync_q == lpc_pkg::CNT_ZERO) begin
                sync_q <= lpc_pkg::SYNC_CYCLES;
            end else if (sync_q == lpc_pkg::CNT_ONE) begin
                targetSlow_q <= 1'b0;
                sync_q       <= lpc_pkg::CNT_ZERO;
            end else begin
                sync_q <= sync_q - lpc_pkg::CNT_ONE;
            end
        end
    end

    // operating mode; not touched by a halt, so release resumes it
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q <= lpc_pkg::MODE_SINGLE_RUN;
        end else if (halt_q == lpc_pkg::HS_RUN) begin
            if (muxOnSlow) begin
                mode_q <= pmReg_q[lpc_pkg::PM_FAST_OSC_BIT]
                    ? lpc_pkg::MODE_SLOW_FAST_ON : lpc_pkg::MODE_SLOW_FAST_OFF;
            end else begin
                mode_q <= pmReg_q[lpc_pkg::PM_SLOW_OSC_BIT]
                    ? lpc_pkg::MODE_DUAL_FAST : lpc_pkg::MODE_SINGLE_RUN;
            end
        end
    end

    // clock gating during deep idle/sleep
    // the hold freezes memory, registers and port latches until the wake edge
    always_ff @(posedge clk) begin
        if (rst) begin
            periphClkEn_q    <= '1;
            cpuHold_q        <= 1'b0;
            lowPowerActive_q <= 1'b0;
        end else begin
            if (enterNow) begin
                periphClkEn_q    <= '0;
                cpuHold_q        <= 1'b1;
                lowPowerActive_q <= 1'b1;
            end else if (releaseNow) begin
                periphClkEn_q    <= '1;
                cpuHold_q        <= 1'b0;
                lowPowerActive_q <= 1'b0;
            end
        end
    end

    // the time base timer keeps its clock in every mode, since it is the wake source
    always_ff @(posedge clk) begin
        if (rst) begin
            tbtClkEn_q <= 1'b1;
        end else begin
            tbtClkEn_q <= 1'b1;
        end
    end

    // resume address captured once the initiating instruction has finished
    always_ff @(posedge clk) begin
        if (rst) begin
            heldPc_q <= 16'h0000;
        end else if (enterNow) begin
            heldPc_q <= instrAddr + lpc_pkg::PC_ADVANCE;
        end
    end

    // time base interrupt latch; a set in the clear cycle wins
    always_ff @(posedge clk) begin
        if (rst) begin
            tbIrqLatch_q <= 1'b0;
        end else if (enterNow && tbReg_q[lpc_pkg::TB_ENABLE_BIT]) begin
            tbIrqLatch_q <= 1'b1;
        end else if (tbIrqLatchClr) begin
            tbIrqLatch_q <= 1'b0;
        end
    end

    // service request only on the interrupt release path; the wake edge is
    // sampled on clk, so the halt may end before a full selected period
    always_ff @(posedge clk) begin
        if (rst) begin
            tbIrqService_q <= 1'b0;
        end else begin
            tbIrqService_q <= releaseNow && irqPath;
        end
    end

    // one-cycle system clock reset request
    always_ff @(posedge clk) begin
        if (rst) begin
            sysClkRstReq_q <= 1'b0;
        end else begin
            sysClkRstReq_q <= xenClearBad;
        end
    end

    // registered copies of the clock gate and oscillator controls
    // the extra flop delays a gate change by one cycle; both gates stay off across it
    always_ff @(posedge clk) begin
        if (rst) begin
            fastClkEn_q <= 1'b1;
            slowClkEn_q <= 1'b0;
            fastOscEn_q <= 1'b1;
            slowOscEn_q <= 1'b0;
        end else begin
            fastClkEn_q <= muxFastEn;
            slowClkEn_q <= muxSlowEn;
            fastOscEn_q <= pmReg_q[lpc_pkg::PM_FAST_OSC_BIT];
            slowOscEn_q <= pmReg_q[lpc_pkg::PM_SLOW_OSC_BIT];
        end
    end

    // readback copies, one cycle behind the registers they mirror
    always_ff @(posedge clk) begin
        if (rst) begin
            opMode_q       <= 2'h0;
            ctrlRdData_q   <= lpc_pkg::PM_RESET;
            tbCtrlRdData_q <= lpc_pkg::TB_RESET;
        end else begin
            opMode_q       <= mode_q;
            ctrlRdData_q   <= pmReg_q;
            tbCtrlRdData_q <= tbReg_q;
        end
    end
endmodule
`default_nettype wire

// [dv/lpc_power_ctrl_checker.sv]
// port-level checks of the power and clock controller
`timescale 1ns/100ps
`default_nettype none
module lpc_power_ctrl_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        instrDone,
    input wire logic [15:0] instrAddr,
    input wire logic        wdtIrq,
    input wire logic        masterIrqEnable,
    input wire logic        tbIrqEnable,
    input wire logic [7:0]  tbSrcLevels,
    input wire logic [7:0]  ctrlRdData_q,
    input wire logic [7:0]  tbCtrlRdData_q,
    input wire logic [7:0]  periphClkEn_q,
    input wire logic        tbtClkEn_q,
    input wire logic        cpuHold_q,
    input wire logic [15:0] heldPc_q,
    input wire logic        tbIrqLatch_q,
    input wire logic        tbIrqService_q,
    input wire logic        lowPowerActive_q,
    input wire logic        fastClkEn_q,
    input wire logic        slowClkEn_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // source select cannot change while halted, so the readback copy is safe here
    logic selLevel;
    assign selLevel = tbSrcLevels[tbCtrlRdData_q[2:0]];
    sequence haltStart;
        $rose(cpuHold_q);
    endsequence
    sequence haltEnd;
        $fell(cpuHold_q);
    endsequence
    sequence toSlow;
        $rose(ctrlRdData_q[5]);
    endsequence
    sequence toFast;
        slowClkEn_q && $fell(ctrlRdData_q[5]);
    endsequence
    chk_gate_halt: assert property (tbtClkEn_q && lowPowerActive_q == cpuHold_q
        && periphClkEn_q == (cpuHold_q ? 8'h00 : 8'hFF)) else $error("clock gating wrong");
    chk_entry_pc: assert property (haltStart |-> $past(instrDone) && !$past(wdtIrq)
        && heldPc_q == $past(instrAddr) + lpc_pkg::PC_ADVANCE) else $error("entry wrong");
    chk_held_frozen: assert property (cpuHold_q && $past(cpuHold_q) |-> $stable(heldPc_q))
        else $error("held pc moved");
    chk_wdt_abort: assert property (instrDone && wdtIrq && !cpuHold_q |=> !cpuHold_q)
        else $error("halt despite watchdog");
    chk_latch_set: assert property (haltStart and tbCtrlRdData_q[7] |-> tbIrqLatch_q)
        else $error("latch not set");
    chk_wake_edge: assert property (haltEnd |-> $past(selLevel, 2) && !$past(selLevel))
        else $error("release without falling edge");
    chk_halt_clear: assert property (haltEnd |=> !ctrlRdData_q[2])
        else $error("halt bit not cleared");
    chk_service_cond: assert property (haltEnd |-> tbIrqService_q ==
        ($past(masterIrqEnable) && $past(tbIrqEnable) && tbCtrlRdData_q[7]))
        else $error("service pulse wrong");
    chk_service_only: assert property (tbIrqService_q |-> haltEnd)
        else $error("stray service pulse");
    chk_gates_excl: assert property (!(fastClkEn_q && slowClkEn_q))
        else $error("both clock gates on");
    chk_to_slow: assert property (toSlow |-> ##[1:8] (slowClkEn_q && !fastClkEn_q))
        else $error("slow switch late");
    chk_fast_sync: assert property (toFast |-> slowClkEn_q [*8] ##[1:20] fastClkEn_q)
        else $error("fast switch timing wrong");
endmodule
`default_nettype wire

// [dv/lpc_power_ctrl_tb_top.sv]
// self-checking bench for the power and clock controller
`timescale 1ns/100ps
`default_nettype none
module lpc_power_ctrl_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ctrlWrEn = 1'b0;
    logic        tbCtrlWrEn = 1'b0;
    logic [7:0]  ctrlWrData = 8'h00;
    logic [7:0]  tbCtrlWrData = 8'h00;
    logic        mie = 1'b0;
    logic        tie = 1'b0;
    logic        latchClr = 1'b0;
    logic [7:0]  levels = 8'h00;
    logic        instrDone = 1'b0;
    logic [15:0] instrAddr = 16'h0000;
    logic        wdtIrq = 1'b0;
    logic [7:0]  ctrlRd, tbRd, periphEn;
    logic [15:0] heldPc;
    logic [1:0]  opMode;
    logic        time_base_enable_bit, cpuHold, latch, service, lpActive, fastEn, slowEn;
    logic        fastOsc, slowOsc, clkRstReq;
    int          miscompares = 0;
    int          checksDone = 0;

    always #2 clk = ~clk;

    lpc_power_ctrl dut (.clk(clk), .rst(rst), .ctrlWrEn(ctrlWrEn), .ctrlWrData(ctrlWrData),
        .tbCtrlWrEn(tbCtrlWrEn), .tbCtrlWrData(tbCtrlWrData), .masterIrqEnable(mie),
        .tbIrqEnable(tie), .tbIrqLatchClr(latchClr), .tbSrcLevels(levels),
        .instrDone(instrDone), .instrAddr(instrAddr), .wdtIrq(wdtIrq), .ctrlRdData_q(ctrlRd),
        .tbCtrlRdData_q(tbRd), .periphClkEn_q(periphEn), .tbtClkEn_q(time_base_enable_bit),
        .cpuHold_q(cpuHold), .heldPc_q(heldPc), .tbIrqLatch_q(latch),
        .tbIrqService_q(service), .lowPowerActive_q(lpActive), .fastClkEn_q(fastEn),
        .slowClkEn_q(slowEn), .fastOscEn_q(fastOsc), .slowOscEn_q(slowOsc),
        .opMode_q(opMode), .sysClkRstReq_q(clkRstReq));

    task automatic tally_and_finish;
        if (miscompares == 0 && checksDone > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic cmp_val(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checksDone++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic cmp_flag(input string nm, input logic exp, input logic got);
        checksDone++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %b seen %b", nm, exp, got);
        end
    endtask

    // one-cycle write strobe; returns once the readback copy has settled
    task automatic wr(input logic tbReg, input logic [7:0] d);
        ctrlWrEn = !tbReg;
        tbCtrlWrEn = tbReg;
        ctrlWrData = d;
        tbCtrlWrData = d;
        @(negedge clk);
        ctrlWrEn = 1'b0;
        tbCtrlWrEn = 1'b0;
        @(negedge clk);
    endtask

    task automatic halt(input logic [15:0] a, input logic wdt);
        wr(1'b0, 8'h84);
        cmp_flag("holdEarly", 1'b0, cpuHold);
        instrAddr = a;
        wdtIrq = wdt;
        instrDone = 1'b1;
        @(negedge clk);
        instrDone = 1'b0;
        wdtIrq = 1'b0;
        @(negedge clk);
    endtask

    // a fall on a neighbouring source must not wake; the selected one must
    task automatic wake(input int k, input logic expSvc);
        int n;
        levels[(k+1)%8] = 1'b1;
        @(negedge clk);
        levels = 8'h00;
        repeat (2) @(negedge clk);
        cmp_flag("holdOther", 1'b1, cpuHold);
        levels[k] = 1'b1;
        @(negedge clk);
        levels[k] = 1'b0;
        for (n = 0; n < 6 && cpuHold !== 1'b0; n++) @(negedge clk);
        cmp_flag("holdEnd", 1'b0, cpuHold);
        cmp_flag("service", expSvc, service);
    endtask

    initial begin
        #40000;
        miscompares++;
        tally_and_finish;
    end

    initial begin
        int n;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        cmp_val("ctrlRd", 16'h0080, 16'(ctrlRd));
        cmp_val("opMode", 16'h0000, 16'(opMode));
        cmp_flag("fastGate", 1'b1, fastEn);
        for (int k = 0; k < 8; k++) begin
            latchClr = 1'b1;
            @(negedge clk);
            latchClr = 1'b0;
            wr(1'b1, {k[2], 4'h0, k[2:0]});
            cmp_val("tbRd", 16'({k[2], 4'h0, k[2:0]}), 16'(tbRd));
            mie = k[1];
            tie = k[0];
            halt(16'h1230 + 16'(k), 1'b0);
            cmp_flag("hold", 1'b1, cpuHold);
            cmp_val("periph", 16'h0000, 16'(periphEn));
            cmp_flag("tbtClk", 1'b1, time_base_enable_bit);
            cmp_val("heldPc", 16'h1232 + 16'(k), heldPc);
            cmp_flag("latch", k[2], latch);
            wr(1'b0, 8'hA0);
            wake(k, k[2] & k[1] & k[0]);
            @(negedge clk);
            cmp_val("ctrlRd", 16'h0080, 16'(ctrlRd));
            cmp_val("opMode", 16'h0000, 16'(opMode));
        end
        halt(16'h2000, 1'b1);
        cmp_flag("holdWdt", 1'b0, cpuHold);
        @(negedge clk);
        cmp_val("ctrlRdWdt", 16'h0080, 16'(ctrlRd));
        halt(16'h3000, 1'b0);
        rst = 1'b1;
        @(negedge clk);
        cmp_flag("holdRst", 1'b0, cpuHold);
        repeat (11) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        wr(1'b0, 8'hC0);
        repeat (4) @(negedge clk);
        cmp_flag("slowOsc", 1'b1, slowOsc);
        wr(1'b0, 8'hE0);
        for (n = 0; n < 12 && slowEn !== 1'b1; n++) @(negedge clk);
        repeat (3) @(negedge clk);
        cmp_flag("slowGate", 1'b1, slowEn);
        cmp_flag("fastGate", 1'b0, fastEn);
        cmp_val("opMode", 16'(lpc_pkg::MODE_SLOW_FAST_ON), 16'(opMode));
        wr(1'b0, 8'h60);
        repeat (2) @(negedge clk);
        cmp_flag("fastOsc", 1'b0, fastOsc);
        cmp_val("opMode", 16'(lpc_pkg::MODE_SLOW_FAST_OFF), 16'(opMode));
        wr(1'b0, 8'hE0);
        wr(1'b0, 8'hC0);
        repeat (6) @(negedge clk);
        cmp_flag("slowHeld", 1'b1, slowEn);
        for (n = 0; n < 30 && fastEn !== 1'b1; n++) @(negedge clk);
        repeat (3) @(negedge clk);
        cmp_flag("fastBack", 1'b1, fastEn);
        cmp_val("opMode", 16'(lpc_pkg::MODE_DUAL_FAST), 16'(opMode));
        ctrlWrData = 8'h40;
        ctrlWrEn = 1'b1;
        @(negedge clk);
        ctrlWrEn = 1'b0;
        for (n = 0; n < 3 && clkRstReq !== 1'b1; n++) @(negedge clk);
        cmp_flag("clkRstReq", 1'b1, clkRstReq);
        repeat (3) @(negedge clk);
        cmp_val("ctrlRd", 16'h00C0, 16'(ctrlRd));
        wr(1'b0, 8'hE0);
        repeat (10) @(negedge clk);
        rst = 1'b1;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        cmp_val("opModeRst", 16'h0000, 16'(opMode));
        cmp_flag("fastGateRst", 1'b1, fastEn);
        tally_and_finish;
    end
endmodule

bind lpc_power_ctrl lpc_power_ctrl_checker u_chk (.clk(clk), .rst(rst),
    .instrDone(instrDone), .instrAddr(instrAddr), .wdtIrq(wdtIrq),
    .masterIrqEnable(masterIrqEnable), .tbIrqEnable(tbIrqEnable), .tbSrcLevels(tbSrcLevels),
    .ctrlRdData_q(ctrlRdData_q), .tbCtrlRdData_q(tbCtrlRdData_q),
    .periphClkEn_q(periphClkEn_q), .tbtClkEn_q(tbtClkEn_q), .cpuHold_q(cpuHold_q),
    .heldPc_q(heldPc_q), .tbIrqLatch_q(tbIrqLatch_q), .tbIrqService_q(tbIrqService_q),
    .lowPowerActive_q(lowPowerActive_q), .fastClkEn_q(fastClkEn_q),
    .slowClkEn_q(slowClkEn_q));
`default_nettype wire
